// *** accessory_regs_pkg.sv ***
// Constants, field layouts and carriers for the accessory status and trim register bank
package accessory_regs_pkg;

	// ======================================================================
	// Register addresses on the six-bit immediate address field
	localparam logic [5:0] ADDR_EVENT_ENABLE = 6'h1d; // Event enable, write
	localparam logic [5:0] ADDR_EVENT_ENABLE_SET = 6'h1e; // Event enable, set
	localparam logic [5:0] ADDR_EVENT_ENABLE_CLR = 6'h1f; // Event enable, clear
	localparam logic [5:0] ADDR_ACCESSORY_STATUS = 6'h20; // Accessory status, read only
	localparam logic [5:0] ADDR_ACCESSORY_EVENT_LATCH = 6'h21; // Event latch, clear on read
	localparam logic [5:0] ADDR_VENDOR_LOW = 6'h30; // First vendor address
	localparam logic [5:0] ADDR_VENDOR_HIGH = 6'h3f; // Last vendor address
	localparam logic [5:0] ADDR_HS_SIGNAL_COMPENSATION = 6'h31; // Squelch and drive trim
	localparam logic [5:0] ADDR_CHARGER_DETECT = 6'h32; // Charger detection
	localparam logic [5:0] ADDR_ID_MEASURE = 6'h36; // Resistor measurement, write
	localparam logic [5:0] ADDR_ID_MEASURE_SET = 6'h37; // Resistor measurement, set
	localparam logic [5:0] ADDR_ID_MEASURE_CLR = 6'h38; // Resistor measurement, clear
	localparam logic [5:0] ADDR_EXTENDED = 6'h2f; // Extended address escape, not served

	// ======================================================================
	// Link command byte encoding
	localparam logic [1:0] CMD_REG_WRITE = 2'h2; // Immediate register write
	localparam logic [1:0] CMD_REG_READ = 2'h3; // Immediate register read
	localparam logic [7:0] RXCMD_ALT_INT = 8'h80; // Alternate interrupt flag of a receive command

	// ======================================================================
	// Writable masks and reset values
	localparam logic [7:0] EVENT_ENABLE_MASK = 8'h27; // Float rise, float fall, comparator, measurement
	localparam logic [7:0] HS_COMP_MASK = 8'h73; // Squelch trim 1:0, drive boost 6:4
	localparam logic [7:0] CHARGER_MASK = 8'h0f; // Charger control bits 3:0
	localparam logic [7:0] ID_MEASURE_MASK = 8'h50; // Start bit 4, irq enable bit 6
	localparam logic [7:0] RESET_BYTE = 8'h00; // Every register resets to zero

	// ======================================================================
	// Field positions
	localparam int EN_ID_OPEN_RISE = 0; // Event enable bit
	localparam int EN_ID_OPEN_FALL = 1; // Event enable bit
	localparam int EN_DATA_VOLTAGE = 2; // Event enable bit
	localparam int EN_ID_MEASURE = 5; // Event enable bit
	localparam int CHG_SINK_ENABLE = 1; // Charger register sink enable bit
	localparam int MEAS_START = 4; // Measurement register start bit
	localparam int MEAS_IRQ_ENABLE = 6; // Measurement register irq enable bit

	// ======================================================================
	// Timing
	localparam longint CLK_PERIOD_PS = 5000; // 200 MHz link clock
	localparam longint MEASURE_TIME_NS = 282000; // Resistor measurement duration
	localparam int MEASURE_CYCLES = int'((MEASURE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

	// ======================================================================
	// Carriers
	typedef struct packed {
		logic reserved; // Bit 7, reads zero
		logic id_measure_complete; // Bit 6
		logic [2:0] id_resistor_code; // Bits 5:3
		logic plus_line_accessory_state; // Bit 2, not implemented
		logic data_line_voltage_seen; // Bit 1
		logic id_open_state; // Bit 0
	} accessory_status_type;

	typedef struct packed {
		logic [3:0] reserved; // Bits 7:4, read zero
		logic id_measure_event; // Bit 3
		logic plus_line_accessory_event; // Bit 2, not implemented
		logic data_voltage_event; // Bit 1
		logic id_open_event; // Bit 0
	} accessory_event_latch_type;

	typedef struct packed {
		logic [2:0] id_resistor_code; // Raw converter result
		logic data_line_voltage_seen; // Raw comparator output
		logic id_open_state; // Raw float detector output
	} analog_inputs_type;

endpackage

// *** accessory_regs.sv ***
// Accessory status, event latch and high-speed trim registers behind the ULPI register port
`timescale 1ns/1ps

// Functional notes
// - Status bit0 shows ID floating, pullup-gated
// - Status bit1 shows sink-gated data comparator
// - Bit2 of status and latch reads zero
// - Status bits 5:3 hold resistor code
// - Completion flag sets after 282 us measurement
// - Vendor measurement read clears completion flag
// - Status register read leaves completion flag
// - Status at 20h read-only, bit7 zero
// - Latch at 21h clears on read
// - Latch bit0 on enabled float edges
// - Latch bit1 on enabled comparator change
// - Latch bit3 on enabled completion rise
// - Vendor 30h-3Fh reached by immediate commands
// - Compensation 31h read-write, reserved bits zero
// - Bits 1:0 scale squelch threshold
// - Bits 6:4 select transmit amplitude boost
// - Enabled events raise alternate interrupt flag
module accessory_regs
	import accessory_regs_pkg::*;
#(
	parameter int MEASURE_LEN = MEASURE_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] ulpi_data_in,
	output logic [7:0] ulpi_data_out,
	output logic ulpi_data_oe,
	output logic ulpi_dir,
	output logic ulpi_nxt,
	input wire logic ulpi_stp,
	input wire analog_inputs_type analog_raw,
	input wire logic id_weak_pullup,
	output logic data_sink_enable,
	output logic measure_active,
	output logic [1:0] squelch_level_trim,
	output logic [2:0] hs_drive_boost
);

	// ======================================================================
	// Declarations
	typedef enum {
		IDLE, WR_DATA, WR_STOP, RD_TURN, RD_DATA, RX_TURN, RX_DATA, TURN_BACK
	} port_state_type;

	port_state_type state_reg; // Register port sequencer
	port_state_type state_next; // Next sequencer state
	logic [5:0] addr_reg; // Address of the command in flight
	logic [7:0] wdata_reg; // Write data captured from the link
	logic [7:0] data_out_reg; // Byte driven toward the link
	logic [7:0] event_enable_reg; // Event enable register
	logic [7:0] hs_comp_reg; // Squelch and drive trim register
	logic [7:0] charger_reg; // Charger detection control bits
	logic [7:0] measure_ctrl_reg; // Start and irq enable of the measurement
	logic [2:0] code_reg; // Last resistor code
	logic done_reg; // Measurement complete flag
	logic [31:0] measure_cnt_reg; // Measurement time counter
	analog_inputs_type sync1_reg; // First synchroniser stage
	analog_inputs_type sync2_reg; // Second synchroniser stage
	analog_inputs_type sync3_reg; // Third synchroniser stage
	analog_inputs_type stable_reg; // Accepted level of every analog input
	logic id_open_prev_reg; // Previous gated float level
	logic vdat_prev_reg; // Previous gated comparator level
	logic done_prev_reg; // Previous completion flag
	accessory_event_latch_type latch_reg; // Event latch register
	logic alt_pending_reg; // Alternate interrupt waiting to be sent
	accessory_status_type status; // Assembled status byte
	logic id_open_level; // Float level after pullup gating
	logic vdat_level; // Comparator level after sink gating
	logic ev_id_open; // Enabled float edge this cycle
	logic ev_vdat; // Enabled comparator change this cycle
	logic ev_measure; // Enabled completion rise this cycle
	logic measure_done_pulse; // Measurement ends this cycle
	logic cmd_seen; // Valid immediate command on the bus
	logic do_write; // Register write commits this cycle
	logic do_read; // Register read is sampled this cycle
	logic [7:0] read_byte; // Read value of the addressed register

	// ======================================================================
	// Helper functions

	// Write, set or clear by address offset within a three-address group
	function automatic logic [7:0] wsc(input logic [7:0] cur, input logic [7:0] wd, input logic [7:0] mask,
		input logic [1:0] mode);
		logic [7:0] r;
		r = cur;
		unique case (mode)
			2'h0: r = wd;
			2'h1: r = cur | wd;
			2'h2: r = cur & ~wd;
			default: r = cur;
		endcase
		return r & mask;
	endfunction

	// Latch set bit: set wins over a simultaneous clear
	function automatic logic sticky(input logic cur, input logic set, input logic clr);
		return set | (cur & ~clr);
	endfunction

	// ======================================================================
	// Analog input synchronisers: a change counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (reset) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
			stable_reg <= '0;
		end else begin
			sync1_reg <= analog_raw;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			// Per-bit acceptance of agreeing stages
			stable_reg <= (sync2_reg & sync3_reg) | (stable_reg & (sync2_reg | sync3_reg));
		end
	end

	// ======================================================================
	// Status assembly
	always_comb begin
		id_open_level = stable_reg.id_open_state & id_weak_pullup;
		vdat_level = stable_reg.data_line_voltage_seen & charger_reg[CHG_SINK_ENABLE];
		status.reserved = 1'b0;
		status.id_measure_complete = done_reg;
		status.id_resistor_code = code_reg;
		status.plus_line_accessory_state = 1'b0;
		status.data_line_voltage_seen = vdat_level;
		status.id_open_state = id_open_level;
	end

	// ======================================================================
	// Resistor measurement timer and result
	always_ff @(posedge clk) begin
		if (reset) begin
			measure_cnt_reg <= '0;
			code_reg <= 3'h0;
		end else if (!measure_ctrl_reg[MEAS_START]) begin
			// Idle: counter held at zero
			measure_cnt_reg <= '0;
		end else if (measure_done_pulse) begin
			// Capture the converter result at the end of the window
			measure_cnt_reg <= '0;
			code_reg <= stable_reg.id_resistor_code;
		end else begin
			measure_cnt_reg <= measure_cnt_reg + 32'h1;
		end
	end

	assign measure_done_pulse = measure_ctrl_reg[MEAS_START] && (measure_cnt_reg == 32'(MEASURE_LEN - 1));
	assign measure_active = measure_ctrl_reg[MEAS_START];

	// Completion flag: set at the end, cleared only by a vendor register read
	always_ff @(posedge clk) begin
		if (reset) begin
			done_reg <= 1'b0;
		end else begin
			// Any of the three measurement addresses returns the code, so any of them clears
			done_reg <= sticky(done_reg, measure_done_pulse,
				do_read && addr_reg >= ADDR_ID_MEASURE && addr_reg <= ADDR_ID_MEASURE_CLR);
		end
	end

	// ======================================================================
	// Edge detection and event latch
	always_ff @(posedge clk) begin
		if (reset) begin
			id_open_prev_reg <= 1'b0;
			vdat_prev_reg <= 1'b0;
			done_prev_reg <= 1'b0;
		end else begin
			id_open_prev_reg <= id_open_level;
			vdat_prev_reg <= vdat_level;
			done_prev_reg <= done_reg;
		end
	end

	always_comb begin
		ev_id_open = (id_open_level && !id_open_prev_reg && event_enable_reg[EN_ID_OPEN_RISE])
			|| (!id_open_level && id_open_prev_reg && event_enable_reg[EN_ID_OPEN_FALL]);
		ev_vdat = (vdat_level != vdat_prev_reg) && event_enable_reg[EN_DATA_VOLTAGE];
		ev_measure = done_reg && !done_prev_reg
			&& (event_enable_reg[EN_ID_MEASURE] || measure_ctrl_reg[MEAS_IRQ_ENABLE]);
	end

	// Latch bits set on events and clear when the latch register is read
	always_ff @(posedge clk) begin
		if (reset) begin
			latch_reg <= '0;
		end else begin
			latch_reg.reserved <= 4'h0;
			latch_reg.plus_line_accessory_event <= 1'b0;
			// New event beats the read clear
			latch_reg.id_open_event <= sticky(latch_reg.id_open_event, ev_id_open,
				do_read && addr_reg == ADDR_ACCESSORY_EVENT_LATCH);
			latch_reg.data_voltage_event <= sticky(latch_reg.data_voltage_event, ev_vdat,
				do_read && addr_reg == ADDR_ACCESSORY_EVENT_LATCH);
			latch_reg.id_measure_event <= sticky(latch_reg.id_measure_event, ev_measure,
				do_read && addr_reg == ADDR_ACCESSORY_EVENT_LATCH);
		end
	end

	// Alternate interrupt request waits until the receive command is sent
	always_ff @(posedge clk) begin
		if (reset) begin
			alt_pending_reg <= 1'b0;
		end else begin
			alt_pending_reg <= sticky(alt_pending_reg, ev_id_open | ev_vdat | ev_measure,
				state_reg == RX_DATA);
		end
	end

	// ======================================================================
	// Writable registers
	always_ff @(posedge clk) begin
		if (reset) begin
			event_enable_reg <= RESET_BYTE;
			hs_comp_reg <= RESET_BYTE;
			charger_reg <= RESET_BYTE;
		end else if (do_write) begin
			// Enable group uses write, set and clear addresses
			if (addr_reg >= ADDR_EVENT_ENABLE && addr_reg <= ADDR_EVENT_ENABLE_CLR) begin
				event_enable_reg <= wsc(event_enable_reg, wdata_reg, EVENT_ENABLE_MASK,
					2'(addr_reg - ADDR_EVENT_ENABLE));
			end
			if (addr_reg == ADDR_HS_SIGNAL_COMPENSATION) begin
				hs_comp_reg <= wdata_reg & HS_COMP_MASK;
			end
			if (addr_reg == ADDR_CHARGER_DETECT) begin
				charger_reg <= wdata_reg & CHARGER_MASK;
			end
		end
	end

	// Measurement control: start clears itself when the measurement ends
	always_ff @(posedge clk) begin
		if (reset) begin
			measure_ctrl_reg <= RESET_BYTE;
		end else if (do_write && addr_reg >= ADDR_ID_MEASURE && addr_reg <= ADDR_ID_MEASURE_CLR) begin
			measure_ctrl_reg <= wsc(measure_ctrl_reg, wdata_reg, ID_MEASURE_MASK,
				2'(addr_reg - ADDR_ID_MEASURE));
		end else if (measure_done_pulse) begin
			measure_ctrl_reg[MEAS_START] <= 1'b0;
		end
	end

	assign squelch_level_trim = hs_comp_reg[1:0];
	assign hs_drive_boost = hs_comp_reg[6:4];
	assign data_sink_enable = charger_reg[CHG_SINK_ENABLE];

	// ======================================================================
	// Read decode
	always_comb begin
		unique case (addr_reg)
			ADDR_EVENT_ENABLE, ADDR_EVENT_ENABLE_SET, ADDR_EVENT_ENABLE_CLR: begin
				read_byte = event_enable_reg;
			end
			ADDR_ACCESSORY_STATUS: begin
				read_byte = status;
			end
			ADDR_ACCESSORY_EVENT_LATCH: begin
				read_byte = latch_reg;
			end
			ADDR_HS_SIGNAL_COMPENSATION: begin
				read_byte = hs_comp_reg;
			end
			ADDR_CHARGER_DETECT: begin
				read_byte = {3'h0, vdat_level, charger_reg[3:0]};
			end
			ADDR_ID_MEASURE, ADDR_ID_MEASURE_SET, ADDR_ID_MEASURE_CLR: begin
				read_byte = measure_ctrl_reg | {4'h0, done_reg, code_reg};
			end
			default: begin
				// Unserved addresses read zero
				read_byte = RESET_BYTE;
			end
		endcase
	end

	// ======================================================================
	// Register port sequencer
	assign cmd_seen = (ulpi_data_in[7:6] == CMD_REG_WRITE || ulpi_data_in[7:6] == CMD_REG_READ)
		&& ulpi_data_in[5:0] != ADDR_EXTENDED;
	assign do_write = (state_reg == WR_STOP) && ulpi_stp;
	assign do_read = (state_reg == RD_TURN);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			IDLE: begin
				// Link commands take priority over a pending interrupt report
				if (cmd_seen) begin
					state_next = (ulpi_data_in[7:6] == CMD_REG_WRITE) ? WR_DATA : RD_TURN;
				end else if (alt_pending_reg && ulpi_data_in == RESET_BYTE) begin
					state_next = RX_TURN;
				end
			end
			WR_DATA: begin
				state_next = ulpi_stp ? IDLE : WR_STOP;
			end
			WR_STOP: begin
				// Write commits only on the stop strobe
				state_next = ulpi_stp ? IDLE : WR_STOP;
			end
			RD_TURN: begin
				state_next = RD_DATA;
			end
			RD_DATA: begin
				state_next = TURN_BACK;
			end
			RX_TURN: begin
				state_next = RX_DATA;
			end
			RX_DATA: begin
				state_next = TURN_BACK;
			end
			TURN_BACK: begin
				state_next = IDLE;
			end
		endcase
	end

	// State, address and write data
	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= IDLE;
			addr_reg <= 6'h0;
			wdata_reg <= RESET_BYTE;
		end else begin
			state_reg <= state_next;
			if (state_reg == IDLE && cmd_seen) begin
				addr_reg <= ulpi_data_in[5:0];
			end
			if (state_reg == WR_DATA) begin
				wdata_reg <= ulpi_data_in;
			end
		end
	end

	// Outgoing byte: read data or receive command with the alternate flag
	always_ff @(posedge clk) begin
		if (reset) begin
			data_out_reg <= RESET_BYTE;
		end else if (state_reg == RD_TURN) begin
			data_out_reg <= read_byte;
		end else if (state_reg == RX_TURN) begin
			data_out_reg <= RXCMD_ALT_INT;
		end else begin
			data_out_reg <= RESET_BYTE;
		end
	end

	// Handshake outputs
	assign ulpi_nxt = (state_reg == IDLE && cmd_seen) || (state_reg == WR_DATA && !ulpi_stp);
	assign ulpi_dir = (state_reg == RD_TURN) || (state_reg == RD_DATA)
		|| (state_reg == RX_TURN) || (state_reg == RX_DATA);
	assign ulpi_data_oe = (state_reg == RD_DATA) || (state_reg == RX_DATA);
	assign ulpi_data_out = data_out_reg;

endmodule

// *** accessory_regs_props.sv ***
// Port checker for the accessory register bank
`timescale 1ns/1ps
module accessory_regs_props
	import accessory_regs_pkg::*;
#(
	parameter int MEASURE_LEN = MEASURE_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] ulpi_data_in,
	input wire logic [7:0] ulpi_data_out,
	input wire logic ulpi_data_oe,
	input wire logic ulpi_dir,
	input wire logic ulpi_nxt,
	input wire logic ulpi_stp,
	input wire logic measure_active,
	input wire logic [1:0] squelch_level_trim,
	input wire logic [2:0] hs_drive_boost
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// ======================================================================
	// Helper count of cycles spent measuring
	logic [31:0] busy_cnt; // Cycles the measurement has run
	always_ff @(posedge clk) begin
		if (reset || !measure_active) begin
			busy_cnt <= 32'h0;
		end else begin
			busy_cnt <= busy_cnt + 32'h1;
		end
	end
	// ======================================================================
	// Command and turnaround sequences
	sequence read_cmd;
		ulpi_nxt && !$past(ulpi_nxt) && ulpi_data_in[7:6] == CMD_REG_READ;
	endsequence
	sequence write_cmd;
		ulpi_nxt && !$past(ulpi_nxt) && ulpi_data_in[7:6] == CMD_REG_WRITE;
	endsequence
	sequence turn_seq;
		(ulpi_dir && !ulpi_data_oe) ##1 (ulpi_dir && ulpi_data_oe) ##1 (!ulpi_dir && !ulpi_data_oe);
	endsequence
	// ======================================================================
	// Assertions
	a_read_turnaround: assert property (read_cmd |=> turn_seq)
		else $error("read command without proper turnaround");
	a_rxcmd_turn: assert property ($rose(ulpi_dir) |-> turn_seq)
		else $error("bus turn of wrong length");
	a_write_accept: assert property (write_cmd |=> (ulpi_nxt || ulpi_stp) && !ulpi_dir ##1 !ulpi_dir)
		else $error("write data beat not accepted");
	a_oe_under_dir: assert property (ulpi_data_oe |-> ulpi_dir)
		else $error("data driven without owning bus");
	a_quiet_data: assert property (!ulpi_data_oe |-> ulpi_data_out == 8'h00)
		else $error("data out not zero while not driving");
	a_rxcmd_byte: assert property (ulpi_data_oe && !$past(ulpi_nxt, 2) |-> ulpi_data_out == RXCMD_ALT_INT)
		else $error("receive command byte wrong");
	a_trim_by_write: assert property (!$stable({squelch_level_trim, hs_drive_boost}) |-> $past(ulpi_stp))
		else $error("trim changed without a write");
	a_measure_len: assert property ($fell(measure_active) |-> busy_cnt >= MEASURE_LEN && busy_cnt <= MEASURE_LEN + 2)
		else $error("measurement length wrong");
endmodule
bind accessory_regs accessory_regs_props #(.MEASURE_LEN(MEASURE_LEN)) u_accessory_regs_props (.clk(clk), .reset(reset),
	.ulpi_data_in(ulpi_data_in), .ulpi_data_out(ulpi_data_out), .ulpi_data_oe(ulpi_data_oe), .ulpi_dir(ulpi_dir),
	.ulpi_nxt(ulpi_nxt), .ulpi_stp(ulpi_stp), .measure_active(measure_active),
	.squelch_level_trim(squelch_level_trim), .hs_drive_boost(hs_drive_boost));

// *** link_model.sv ***
// Link-side model issuing immediate register reads and writes
`timescale 1ns/1ps
module link_model
	import accessory_regs_pkg::*;
(
	input wire logic clk,
	input wire logic ulpi_dir,
	input wire logic ulpi_nxt,
	input wire logic ulpi_data_oe,
	input wire logic [7:0] ulpi_data_out,
	output logic [7:0] ulpi_data_in,
	output logic ulpi_stp
);
	logic [7:0] drv = 8'h00; // Byte the link drives
	logic [7:0] drv_last = 8'h00; // Last byte driven before a turn
	logic dir_q = 1'b0; // Direction one cycle ago
	int alt_count = 0; // Alternate interrupt bytes seen
	initial ulpi_stp = 1'b0;
	// Released bus shows the inverse of the last byte, never a stale copy
	assign ulpi_data_in = ulpi_dir ? ~drv_last : drv;
	// Track direction and count alternate interrupt bytes
	always @(posedge clk) begin
		dir_q <= ulpi_dir;
		if (!ulpi_dir) drv_last <= drv;
		if (ulpi_data_oe && ulpi_data_out === RXCMD_ALT_INT) alt_count <= alt_count + 1;
	end
	// Wait until the device owns neither the bus nor its turn cycle
	task automatic claim();
		@(posedge clk) #1;
		while (ulpi_dir || dir_q) @(posedge clk) #1;
	endtask
	// Immediate write: command, data, stop
	task automatic wr(input logic [5:0] addr, input logic [7:0] data);
		claim();
		drv = {CMD_REG_WRITE, addr};
		@(posedge clk) #1;
		drv = data;
		@(posedge clk) #1;
		drv = 8'h00;
		ulpi_stp = 1'b1;
		@(posedge clk) #1;
		ulpi_stp = 1'b0;
	endtask
	// Immediate read: command, turn, data, turn back
	task automatic rd(input logic [5:0] addr, output logic [7:0] data);
		claim();
		drv = {CMD_REG_READ, addr};
		@(posedge clk) #1;
		drv = 8'h00;
		@(posedge clk) #1;
		data = ulpi_data_out;
		@(posedge clk) #1;
	endtask
endmodule

// *** tb_top.sv ***
// Self-checking bench for the accessory register bank
`timescale 1ns/1ps
module tb_top;
	import accessory_regs_pkg::*;
	localparam int MLEN = 20; // Shortened measurement
	logic clk, reset, ulpi_stp, id_weak_pullup, ulpi_data_oe, ulpi_dir, ulpi_nxt, data_sink_enable, measure_active;
	logic [7:0] ulpi_data_in, ulpi_data_out, rd;
	logic [1:0] squelch_level_trim;
	logic [2:0] hs_drive_boost;
	analog_inputs_type analog_raw;
	int failures = 0, total_checks = 0, cycles = 0;
	// ======================================================================
	// Design and link partner
	accessory_regs #(.MEASURE_LEN(MLEN)) u_accessory_regs (.clk(clk), .reset(reset), .ulpi_data_in(ulpi_data_in),
		.ulpi_data_out(ulpi_data_out), .ulpi_data_oe(ulpi_data_oe), .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt),
		.ulpi_stp(ulpi_stp), .analog_raw(analog_raw), .id_weak_pullup(id_weak_pullup),
		.data_sink_enable(data_sink_enable), .measure_active(measure_active),
		.squelch_level_trim(squelch_level_trim), .hs_drive_boost(hs_drive_boost));
	link_model u_link_model (.clk(clk), .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt), .ulpi_data_oe(ulpi_data_oe),
		.ulpi_data_out(ulpi_data_out), .ulpi_data_in(ulpi_data_in), .ulpi_stp(ulpi_stp));
	// ======================================================================
	// Clock, timeout, compare and verdict
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic settle();
		repeat (8) @(posedge clk);
		#1;
	endtask
	// ======================================================================
	// Scenarios
	// Reset values of the status, latch and compensation registers
	task automatic test_reset();
		u_link_model.rd(ADDR_ACCESSORY_STATUS, rd);
		chk(rd, 8'h00);
		u_link_model.rd(ADDR_ACCESSORY_EVENT_LATCH, rd);
		chk(rd, 8'h00);
		u_link_model.rd(ADDR_HS_SIGNAL_COMPENSATION, rd);
		chk(rd, 8'h00);
	endtask
	// Every trim code, reserved bits, unmapped and read-only writes
	task automatic test_comp();
		for (int i = 0; i < 8; i++) begin
			u_link_model.wr(ADDR_HS_SIGNAL_COMPENSATION, {1'b1, 3'(i), 2'b11, 2'(i)});
			u_link_model.rd(ADDR_HS_SIGNAL_COMPENSATION, rd);
			chk(rd, {1'b0, 3'(i), 2'b00, 2'(i)});
			chk({6'h00, squelch_level_trim}, {6'h00, 2'(i)});
			chk({5'h00, hs_drive_boost}, {5'h00, 3'(i)});
		end
		u_link_model.wr(6'h3c, 8'hff);
		u_link_model.rd(6'h3c, rd);
		chk(rd, 8'h00);
		u_link_model.wr(ADDR_ACCESSORY_STATUS, 8'hff);
		u_link_model.rd(ADDR_ACCESSORY_STATUS, rd);
		chk(rd, 8'h00);
	endtask
	// Float and comparator levels, their gating and latched edges
	task automatic test_events();
		u_link_model.wr(ADDR_EVENT_ENABLE, 8'h27);
		u_link_model.wr(ADDR_CHARGER_DETECT, 8'h02);
		chk({7'h00, data_sink_enable}, 8'h01);
		id_weak_pullup = 1'b1;
		analog_raw = {3'h5, 1'b1, 1'b1};
		settle();
		u_link_model.rd(ADDR_ACCESSORY_STATUS, rd);
		chk(rd, 8'h03);
		u_link_model.rd(ADDR_ACCESSORY_EVENT_LATCH, rd);
		chk(rd, 8'h03);
		u_link_model.rd(ADDR_ACCESSORY_EVENT_LATCH, rd);
		chk(rd, 8'h00);
		id_weak_pullup = 1'b0;
		u_link_model.wr(ADDR_CHARGER_DETECT, 8'h00);
		settle();
		u_link_model.rd(ADDR_ACCESSORY_STATUS, rd);
		chk(rd, 8'h00);
		u_link_model.rd(ADDR_ACCESSORY_EVENT_LATCH, rd);
		chk(rd, 8'h03);
		chk({7'h00, u_link_model.alt_count != 0}, 8'h01);
		// Float rise lands on the very edge at which the latch read clears
		fork
			u_link_model.rd(ADDR_ACCESSORY_EVENT_LATCH, rd);
			begin
				@(posedge ulpi_dir) #1;
				id_weak_pullup = 1'b1;
			end
		join
		chk(rd, 8'h00);
		u_link_model.rd(ADDR_ACCESSORY_EVENT_LATCH, rd);
		chk(rd, 8'h01);
		id_weak_pullup = 1'b0;
		u_link_model.rd(ADDR_ACCESSORY_EVENT_LATCH, rd);
		chk(rd, 8'h01);
	endtask
	// Measurement flag, its clearing paths and every resistor code
	task automatic test_measure();
		u_link_model.wr(ADDR_ID_MEASURE, 8'h10);
		chk({7'h00, measure_active}, 8'h01);
		repeat (MLEN + 10) @(posedge clk);
		u_link_model.rd(ADDR_ACCESSORY_STATUS, rd);
		chk(rd, 8'h68);
		u_link_model.rd(ADDR_ACCESSORY_STATUS, rd);
		chk(rd, 8'h68);
		u_link_model.rd(ADDR_ACCESSORY_EVENT_LATCH, rd);
		chk(rd, 8'h08);
		u_link_model.rd(ADDR_ID_MEASURE, rd);
		chk(rd, 8'h0d);
		u_link_model.rd(ADDR_ACCESSORY_STATUS, rd);
		chk(rd, 8'h28);
		for (int c = 0; c < 8; c++) begin
			analog_raw = {3'(c), 1'b0, 1'b0};
			settle();
			u_link_model.wr(ADDR_ID_MEASURE_SET, 8'h10);
			repeat (MLEN + 10) @(posedge clk);
			u_link_model.rd(ADDR_ACCESSORY_STATUS, rd);
			chk(rd, {2'b01, 3'(c), 3'b000});
			u_link_model.rd(ADDR_ID_MEASURE, rd);
			chk(rd, {5'b00001, 3'(c)});
		end
	endtask
	// ======================================================================
	// Main sequence
	initial begin
		reset = 1'b1;
		id_weak_pullup = 1'b0;
		analog_raw = '0;
		repeat (8) @(posedge clk);
		#1;
		reset = 1'b0;
		test_reset();
		test_comp();
		test_events();
		test_measure();
		print_verdict();
	end
endmodule
